// file: timer_pkg.sv
package timer_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_CH   = 5;
    localparam int CNT_W    = 16;
    localparam int NUM_GEN  = 4;
    localparam int NUM_TAPS = 4;

    // ****************************************
    // Register map
    // ****************************************
    localparam int CH_LSB  = 5;
    localparam int IDX_LSB = 2;
    localparam logic [2:0] STATUS_IDX  = 3'h0;
    localparam logic [2:0] COUNTER_IDX = 3'h1;
    localparam logic [2:0] CTRL_IDX    = 3'h2;
    localparam logic [2:0] GEN_A_IDX   = 3'h3;

    // ****************************************
    // Status fields and reset values
    // ****************************************
    localparam int ST_DIR = 7;
    localparam int ST_RSV = 6;
    localparam int ST_UNF = 5;
    localparam int ST_OVF = 4;
    localparam logic [7:0]  STATUS_RESET  = 8'hc0;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] GEN_RESET     = 16'hffff;
    localparam logic [10:0] CTRL_RESET    = 11'h000;

    typedef struct packed {
        logic [3:0] capture_sel;
        logic [1:0] prescale;
        logic       irq_en;
        logic       cascade;
        logic       down;
        logic       updown;
        logic       start;
    } chan_ctrl_t;

    typedef struct packed {
        logic [4:0] dma_a;
        logic [4:0] dtc_b;
        logic [4:0] dtc_c;
        logic [4:0] dtc_d;
        logic       dtc_ovf4;
    } xfer_ack_t;

    typedef struct packed {
        logic [2:0] ch;
        logic [2:0] idx;
    } bus_req_t;

endpackage : timer_pkg

// file: timer_prescaler.sv
module timer_prescaler #(
    parameter int N_TAPS = 4
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    output logic      [N_TAPS-1:0] o_tick
);

    localparam int DW = 2 * (N_TAPS - 1);

    logic [DW-1:0] div;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    // Tap k pulses once every 4**k cycles
    assign o_tick[0] = 1'b1;
    genvar k;
    generate
        for (k = 1; k < N_TAPS; k++) begin : g_tap
            assign o_tick[k] = &div[2*k-1:0];
        end
    endgenerate

endmodule : timer_prescaler

// file: timer_channel.sv
module timer_channel #(
    parameter int CH = 0,
    parameter int W  = 16
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_tick,
    input  timer_pkg::chan_ctrl_t    i_ctrl,
    input  wire logic                i_casc_ovf,
    input  wire logic                i_casc_unf,
    input  wire logic [3:0]          i_cap,
    input  wire logic                i_stat_rd,
    input  wire logic                i_stat_wr,
    input  wire logic                i_cnt_wr,
    input  wire logic [3:0]          i_gen_wr,
    input  wire logic [W-1:0]        i_wdata,
    input  wire logic [3:0]          i_ack,
    input  wire logic                i_ovf_ack,
    output logic      [7:0]          o_status,
    output logic      [W-1:0]        o_count,
    output logic      [4*W-1:0]      o_gen,
    output logic                     o_ovf_evt,
    output logic                     o_unf_evt
);

    localparam bit HAS_UNF = (CH == 1) || (CH == 2);
    localparam bit HAS_CD  = !HAS_UNF;
    localparam logic [5:0] VALID = {HAS_UNF, 1'b1, HAS_CD, HAS_CD, 2'b11};

    logic [W-1:0] count;
    logic [W-1:0] gen [4];
    logic [W-1:0] next_count;
    logic [5:0]   flags;
    logic [5:0]   armed;
    logic [5:0]   set;
    logic [5:0]   clr;
    logic [5:0]   wbits;
    logic         dir;
    logic         moved;
    logic         updown_ok;
    logic         step;
    logic         down;
    logic         wrap_up;
    logic         wrap_dn;
    logic         dec_one;

    // ****************************************
    // Counting
    // ****************************************
    always_comb begin
        updown_ok = 1'b0;
        if (HAS_UNF) begin
            updown_ok = i_ctrl.updown | i_ctrl.cascade;
        end else if (CH >= 3) begin
            updown_ok = i_ctrl.updown;
        end
        if (HAS_UNF && i_ctrl.cascade) begin
            step = i_ctrl.start & (i_casc_ovf | i_casc_unf);
            down = i_casc_unf;
        end else begin
            step = i_ctrl.start & i_tick;
            down = updown_ok & i_ctrl.down;
        end
        next_count = down ? count - 1'b1 : count + 1'b1;
        wrap_up = step & ~down & (&count);
        wrap_dn = step & down & (count == '0);
        dec_one = step & down & (count == W'(1));
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count <= W'(timer_pkg::COUNTER_RESET);
        end else if (i_cnt_wr) begin
            count <= i_wdata;
        end else if (step) begin
            count <= next_count;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dir       <= 1'b1;
            moved     <= 1'b0;
            o_ovf_evt <= 1'b0;
            o_unf_evt <= 1'b0;
        end else begin
            if (step && CH != 0) begin
                dir <= ~down;
            end
            moved     <= step & ~i_cnt_wr;
            o_ovf_evt <= wrap_up;
            o_unf_evt <= wrap_dn;
        end
    end

    // ****************************************
    // General registers, match and capture
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_gen
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    gen[g] <= W'(timer_pkg::GEN_RESET);
                end else if (i_gen_wr[g]) begin
                    gen[g] <= i_wdata;
                end else if (i_cap[g] && i_ctrl.capture_sel[g]) begin
                    gen[g] <= count;
                end
            end
            assign set[g] = i_ctrl.capture_sel[g]
                ? i_cap[g]
                : moved & (count == gen[g]);
            assign o_gen[g*W +: W] = gen[g];
        end
    endgenerate

    // ****************************************
    // Status flags
    // ****************************************
    assign set[4] = wrap_up | ((CH == 4) & dec_one);
    assign set[5] = wrap_dn;
    assign wbits  = {i_wdata[timer_pkg::ST_UNF],
                     i_wdata[timer_pkg::ST_OVF], i_wdata[3:0]};

    always_comb begin
        clr = {1'b0, i_ovf_ack & (CH == 4), i_ack};
        if (i_stat_wr) begin
            clr = clr | (armed & ~wbits);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags <= timer_pkg::STATUS_RESET[5:0];
            armed <= 6'h00;
        end else begin
            flags <= ((flags & ~clr) | set) & VALID;
            if (i_stat_wr) begin
                armed <= 6'h00;
            end else if (i_stat_rd) begin
                armed <= armed | flags;
            end
        end
    end

    assign o_status = {dir, 1'b1, flags};
    assign o_count  = count;

endmodule : timer_channel

// file: timer_status_top.sv
// What this block does
// - Writing 1 never sets a flag
// - Direction flag: 0 down, 1 up, resets 1
// - Channel 0 direction bit reads 1
// - Status bit 6 always reads 1
// - Channels 1, 2 underflow on 0 to FFFF
// - Underflow clears by 0 after read 1
// - Channels 0, 3, 4 underflow reads 0
// - Overflow sets on FFFF to 0
// - Channel 4 overflow also on 1 to 0
// - Channel 4 overflow cleared by transfer ack
// - Compare match sets its flag
// - Input capture copies counter, sets flag
// - Match flag clears by 0 after read 1
// - Flag A cleared by DMA transfer
// - Flags B-D cleared by data transfer
// - Channels 1, 2 flags C, D read 0
// - Five read/write 16-bit counters
// - Counters reset by power-on and standby only
// - Channels 1, 2 up/down only when allowed
// - Channel 0 up only; 3, 4 count down only with updown set
// - Status reset by power-on, standby only
// - Overflow interrupt only when enabled
module timer_status_top (
    input  wire logic                  I_SYS_CLK,
    input  wire logic                  I_RESET,
    input  wire logic                  I_STANDBY,
    input  wire logic                  I_MANUAL_RESET,
    input  wire logic                  I_HSEL,
    input  wire logic [31:0]           I_HADDR,
    input  wire logic [1:0]            I_HTRANS,
    input  wire logic                  I_HWRITE,
    input  wire logic [2:0]            I_HSIZE,
    input  wire logic [31:0]           I_HWDATA,
    input  wire logic                  I_HREADY,
    input  wire logic [19:0]           I_CAPTURE,
    input  timer_pkg::xfer_ack_t       I_XFER_ACK,
    output logic      [31:0]           O_HRDATA,
    output logic                       O_HREADYOUT,
    output logic                       O_HRESP,
    output logic      [4:0]            O_IRQ_OVF
);

    localparam int N = timer_pkg::NUM_CH;
    localparam int W = timer_pkg::CNT_W;

    // ****************************************
    // Resets
    // ****************************************
    // Counters and flags survive a manual reset; only the bus
    // interface restarts so a half-done transfer cannot hang.
    logic chan_rst;
    logic bus_rst;

    assign chan_rst = I_RESET | I_STANDBY;
    assign bus_rst  = chan_rst | I_MANUAL_RESET;

    // ****************************************
    // Decoding
    // ****************************************
    function automatic logic mapped(input logic [2:0] ch,
                                    input logic [2:0] idx);
        logic narrow;
        narrow = (ch == 3'h1) || (ch == 3'h2);
        if (ch >= 3'(N)) begin
            mapped = 1'b0;
        end else if (idx < timer_pkg::GEN_A_IDX) begin
            mapped = 1'b1;
        end else if (narrow) begin
            mapped = idx < timer_pkg::GEN_A_IDX + 3'h2;
        end else begin
            mapped = idx < timer_pkg::GEN_A_IDX + 3'h4;
        end
    endfunction : mapped

    function automatic logic hit(input timer_pkg::bus_req_t r,
                                 input int c,
                                 input logic [2:0] idx);
        hit = (r.ch == 3'(c)) && (r.idx == idx) && mapped(r.ch, r.idx);
    endfunction : hit

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    // Writes finish with no wait state; reads take one wait state
    // so a read right after a write sees the written value.
    timer_pkg::bus_req_t req;
    logic                take;
    logic                wr_pend;
    logic                rd_pend;

    assign take = I_HSEL & I_HREADY & I_HTRANS[1];

    always_ff @(posedge I_SYS_CLK) begin
        if (bus_rst) begin
            req <= '0;
        end else if (take) begin
            req.ch  <= I_HADDR[timer_pkg::CH_LSB +: 3];
            req.idx <= I_HADDR[timer_pkg::IDX_LSB +: 3];
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (bus_rst) begin
            wr_pend     <= 1'b0;
            rd_pend     <= 1'b0;
            O_HREADYOUT <= 1'b1;
        end else begin
            wr_pend <= take & I_HWRITE;
            rd_pend <= take & ~I_HWRITE;
            if (take && !I_HWRITE) begin
                O_HREADYOUT <= 1'b0;
            end else if (rd_pend) begin
                O_HREADYOUT <= 1'b1;
            end
        end
    end

    // Errors are never signalled; unmapped reads return zero
    always_ff @(posedge I_SYS_CLK) begin
        if (bus_rst) begin
            O_HRESP <= 1'b0;
        end else begin
            O_HRESP <= 1'b0;
        end
    end

    // ****************************************
    // Capture inputs
    // ****************************************
    logic [19:0] cap_s1;
    logic [19:0] cap_s2;
    logic [19:0] cap_s3;
    logic [19:0] cap_pulse;

    always_ff @(posedge I_SYS_CLK) begin
        if (chan_rst) begin
            cap_s1 <= 20'h00000;
            cap_s2 <= 20'h00000;
            cap_s3 <= 20'h00000;
        end else begin
            cap_s1 <= I_CAPTURE;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
        end
    end

    // Rising edge only; both-edge capture is not offered
    assign cap_pulse = cap_s2 & ~cap_s3;

    // ****************************************
    // Prescaler
    // ****************************************
    logic [timer_pkg::NUM_TAPS-1:0] taps;

    timer_prescaler #(
        .N_TAPS (timer_pkg::NUM_TAPS)
    ) u_prescaler (
        .i_clk  (I_SYS_CLK),
        .i_rst  (chan_rst),
        .o_tick (taps)
    );

    // ****************************************
    // Channels
    // ****************************************
    timer_pkg::chan_ctrl_t ctrl [N];
    logic [7:0]            status [N];
    logic [W-1:0]          count [N];
    logic [4*W-1:0]        gen [N];
    logic [N-1:0]          ovf_evt;
    logic [N-1:0]          unf_evt;
    logic [N-1:0]          casc_ovf;
    logic [N-1:0]          casc_unf;
    logic [N-1:0]          stat_rd;
    logic [N-1:0]          stat_wr;
    logic [N-1:0]          cnt_wr;
    logic [N-1:0]          ctrl_wr;
    logic [3:0]            gen_wr [N];
    logic [3:0]            ack [N];

    // Channels 1 and 2 may count each other's wraps
    assign casc_ovf = {2'b00, ovf_evt[1], ovf_evt[2], 1'b0};
    assign casc_unf = {2'b00, unf_evt[1], unf_evt[2], 1'b0};

    genvar c;
    genvar g;
    generate
        for (c = 0; c < N; c++) begin : g_ch
            assign stat_rd[c] = rd_pend & hit(req, c,
                                timer_pkg::STATUS_IDX);
            assign stat_wr[c] = wr_pend & hit(req, c,
                                timer_pkg::STATUS_IDX);
            assign cnt_wr[c]  = wr_pend & hit(req, c,
                                timer_pkg::COUNTER_IDX);
            assign ctrl_wr[c] = wr_pend & hit(req, c,
                                timer_pkg::CTRL_IDX);
            for (g = 0; g < 4; g++) begin : g_gw
                assign gen_wr[c][g] = wr_pend & hit(req, c,
                        timer_pkg::GEN_A_IDX + 3'(g));
            end

            assign ack[c] = {I_XFER_ACK.dtc_d[c],
                             I_XFER_ACK.dtc_c[c],
                             I_XFER_ACK.dtc_b[c],
                             I_XFER_ACK.dma_a[c]};

            always_ff @(posedge I_SYS_CLK) begin
                if (chan_rst) begin
                    ctrl[c] <= timer_pkg::CTRL_RESET;
                end else if (ctrl_wr[c]) begin
                    ctrl[c] <= I_HWDATA[10:0];
                end
            end

            timer_channel #(
                .CH (c),
                .W  (W)
            ) u_chan (
                .i_clk      (I_SYS_CLK),
                .i_rst      (chan_rst),
                .i_tick     (taps[ctrl[c].prescale]),
                .i_ctrl     (ctrl[c]),
                .i_casc_ovf (casc_ovf[c]),
                .i_casc_unf (casc_unf[c]),
                .i_cap      (cap_pulse[4*c +: 4]),
                .i_stat_rd  (stat_rd[c]),
                .i_stat_wr  (stat_wr[c]),
                .i_cnt_wr   (cnt_wr[c]),
                .i_gen_wr   (gen_wr[c]),
                .i_wdata    (I_HWDATA[W-1:0]),
                .i_ack      (ack[c]),
                .i_ovf_ack  (I_XFER_ACK.dtc_ovf4),
                .o_status   (status[c]),
                .o_count    (count[c]),
                .o_gen      (gen[c]),
                .o_ovf_evt  (ovf_evt[c]),
                .o_unf_evt  (unf_evt[c])
            );

            always_ff @(posedge I_SYS_CLK) begin
                if (chan_rst) begin
                    O_IRQ_OVF[c] <= 1'b0;
                end else begin
                    O_IRQ_OVF[c] <= status[c][timer_pkg::ST_OVF]
                                  & ctrl[c].irq_en;
                end
            end
        end
    endgenerate

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] rd_word;
    logic [2:0]  gsel;

    always_comb begin
        rd_word = 32'h00000000;
        gsel    = req.idx - timer_pkg::GEN_A_IDX;
        if (mapped(req.ch, req.idx)) begin
            case (req.idx)
                timer_pkg::STATUS_IDX: begin
                    rd_word[7:0] = status[req.ch];
                end
                timer_pkg::COUNTER_IDX: begin
                    rd_word[W-1:0] = count[req.ch];
                end
                timer_pkg::CTRL_IDX: begin
                    rd_word[10:0] = ctrl[req.ch];
                end
                default: begin
                    rd_word[W-1:0] = gen[req.ch][gsel[1:0]*W +: W];
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (bus_rst) begin
            O_HRDATA <= 32'h00000000;
        end else if (rd_pend) begin
            O_HRDATA <= rd_word;
        end
    end

endmodule : timer_status_top

// file: timer_status_top_asserts.sv
module timer_status_asserts (
    input wire logic        I_SYS_CLK,
    input wire logic        I_RESET,
    input wire logic        I_STANDBY,
    input wire logic        I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0]  I_HTRANS,
    input wire logic        I_HWRITE,
    input wire logic        I_HREADY,
    input wire logic [31:0] O_HRDATA,
    input wire logic        O_HREADYOUT,
    input wire logic [4:0]  O_IRQ_OVF
);
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RESET);

    logic       take;
    logic       rd_open;
    logic [7:0] rd_addr;
    logic [2:0] ch;
    logic       st_rd;
    logic       cnt_rd;

    // ****************************************
    // Read data phase tracking
    // ****************************************
    assign take   = I_HSEL && I_HREADY && I_HTRANS[1];
    assign ch     = rd_addr[7:5];
    assign st_rd  = rd_open && O_HREADYOUT && rd_addr[4:2] == 3'h0
                    && ch < 3'h5;
    assign cnt_rd = rd_open && O_HREADYOUT && rd_addr[4:2] == 3'h1
                    && ch < 3'h5;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            rd_open <= 1'b0;
        end else if (take) begin
            rd_open <= !I_HWRITE;
        end else if (O_HREADYOUT) begin
            rd_open <= 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (take) begin
            rd_addr <= I_HADDR[7:0];
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    property p_rsv6;
        st_rd |-> O_HRDATA[6];
    endproperty
    a_rsv6: assert property (p_rsv6)
        else $error("status bit 6 read as 0");

    property p_ch0_dir;
        st_rd && ch == 3'h0 |-> O_HRDATA[7];
    endproperty
    a_ch0_dir: assert property (p_ch0_dir)
        else $error("channel 0 direction bit read as 0");

    property p_unf_rsv;
        st_rd && (ch == 3'h0 || ch >= 3'h3) |-> !O_HRDATA[5];
    endproperty
    a_unf_rsv: assert property (p_unf_rsv)
        else $error("reserved underflow bit read as 1");

    property p_cd_rsv;
        st_rd && (ch == 3'h1 || ch == 3'h2) |-> O_HRDATA[3:2] == 2'b00;
    endproperty
    a_cd_rsv: assert property (p_cd_rsv)
        else $error("reserved match flags C D read as 1");

    property p_cnt_width;
        cnt_rd |-> O_HRDATA[31:16] == 16'h0000;
    endproperty
    a_cnt_width: assert property (p_cnt_width)
        else $error("counter read wider than 16 bits");

    property p_rd_wait;
        take && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read answer timing wrong");

    property p_reset_irq;
        $fell(I_RESET) |-> O_IRQ_OVF == 5'h00;
    endproperty
    a_reset_irq: assert property (p_reset_irq)
        else $error("overflow request left after reset");

    property p_standby_irq;
        $fell(I_STANDBY) |=> O_IRQ_OVF == 5'h00;
    endproperty
    a_standby_irq: assert property (p_standby_irq)
        else $error("overflow request left after standby");

    c_status_read: cover property (st_rd);
    c_count_read: cover property (cnt_rd);
    c_irq: cover property ($rose(O_IRQ_OVF[4]));
endmodule : timer_status_asserts

bind timer_status_top timer_status_asserts timer_status_asserts_i (
    .I_SYS_CLK  (I_SYS_CLK),
    .I_RESET    (I_RESET),
    .I_STANDBY  (I_STANDBY),
    .I_HSEL     (I_HSEL),
    .I_HADDR    (I_HADDR),
    .I_HTRANS   (I_HTRANS),
    .I_HWRITE   (I_HWRITE),
    .I_HREADY   (I_HREADY),
    .O_HRDATA   (O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT),
    .O_IRQ_OVF  (O_IRQ_OVF)
);

// file: timer_xfer_model.sv
module timer_xfer_model (
    input  wire logic           i_clk,
    input  wire logic           i_go,
    input  wire logic [3:0]     i_delay,
    input  timer_pkg::xfer_ack_t i_sel,
    output timer_pkg::xfer_ack_t o_ack
);
    timeunit 1ns;
    timeprecision 100ps;

    initial o_ack = '0;

    // ****************************************
    // Transfer units finishing a triggered move
    // ****************************************
    always @(posedge i_clk) begin
        if (i_go) begin
            repeat (i_delay) @(posedge i_clk);
            o_ack <= i_sel;
            @(posedge i_clk);
            o_ack <= '0;
        end
    end
endmodule : timer_xfer_model

// file: timer_channel_status_and_counter_tb.sv
module timer_channel_status_and_counter_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 clk, rst, stby, mrst, hsel, hwrite, go;
    logic [31:0]          haddr, hwdata, rdata;
    logic [1:0]           htrans;
    logic [19:0]          cap;
    logic [3:0]           dly;
    timer_pkg::xfer_ack_t sel, ack;
    wire logic [31:0]     hrdata;
    wire logic            hready, hresp;
    wire logic [4:0]      irq;
    int                   bad_count, comparisons;
    int                   cs[3] = '{0, 2, 3};
    logic [31:0]          ctl[3] = '{32'h7, 32'h5, 32'h5};

    timer_status_top timer_status_top_i (
        .I_SYS_CLK(clk), .I_RESET(rst), .I_STANDBY(stby),
        .I_MANUAL_RESET(mrst), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hready), .I_CAPTURE(cap),
        .I_XFER_ACK(ack), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
        .O_HRESP(hresp), .O_IRQ_OVF(irq));

    timer_xfer_model timer_xfer_model_i (.i_clk(clk), .i_go(go),
        .i_delay(dly), .i_sel(sel), .o_ack(ack));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // ****************************************
    // Bus master
    // ****************************************
    // Sampled at the falling edge, so the edge itself never races
    task automatic wait_rdy(output logic [31:0] d);
        int   n;
        logic r;
        n = 0;
        do begin
            @(negedge clk);
            r = hready;
            d = hrdata;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 64);
        if (r !== 1'b1) begin
            bad_count++;
            final_report();
        end
    endtask : wait_rdy

    // Whole-word accesses only
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        logic [31:0] x;
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy(x);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy(q);
    endtask : bus

    function automatic logic [31:0] ad(input int c, input int i);
        return 32'(c * 32 + i * 4);
    endfunction : ad

    task automatic wr(input int c, input int i, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, ad(c, i), d, q);
    endtask : wr

    task automatic rc(input int c, input int i, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, ad(c, i), 32'h0, q);
        check(q, e);
    endtask : rc

    task automatic xack(input logic [20:0] s, input logic [3:0] d);
        @(posedge clk);
        sel <= s;
        dly <= d;
        go  <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : xack

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        final_report();
    end

    initial begin
        {rst, stby, mrst, hsel, hwrite, go} = 6'b100000;
        {haddr, hwdata, htrans, cap, dly, sel} = '0;
        bad_count = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int c = 0; c < 5; c++) begin
            rc(c, 0, 32'hc0);
            wr(c, 0, 32'hff);
            rc(c, 0, 32'hc0);
            rc(c, 1, 32'h0);
            wr(c, 1, 32'h1000 + 32'(c));
            rc(c, 1, 32'h1000 + 32'(c));
        end
        rc(1, 5, 32'h0);
        rc(5, 0, 32'h0);
        check(32'(hresp), 32'h0);
        // ****************************************
        // Overflow, match flags and request on channel 4
        // ****************************************
        wr(4, 1, 32'hfffe);
        wr(4, 2, 32'h11);
        wr(4, 2, 32'h10);
        rc(4, 0, 32'hdf);
        @(negedge clk);
        check(32'(irq), 32'h10);
        wr(4, 0, 32'hff);
        wr(4, 0, 32'h0);
        rc(4, 0, 32'hdf);
        wr(4, 0, 32'h0);
        rc(4, 0, 32'hc0);
        @(negedge clk);
        check(32'(irq), 32'h0);
        // Transfer acknowledges, prompt and slow
        wr(4, 1, 32'hfffe);
        wr(4, 2, 32'h1);
        wr(4, 2, 32'h0);
        xack(21'h000001, 4'h0);
        rc(4, 0, 32'hcf);
        xack(21'h100000, 4'h3);
        rc(4, 0, 32'hce);
        xack(21'h008420, 4'h1);
        rc(4, 0, 32'hc0);
        // ****************************************
        // Down counting
        // ****************************************
        wr(1, 1, 32'h1);
        wr(1, 2, 32'h7);
        repeat (4) @(posedge clk);
        rc(1, 0, 32'h63);
        // Direction holds while stopped, so count up briefly
        wr(1, 2, 32'h1);
        wr(1, 2, 32'h0);
        rc(1, 0, 32'he3);
        wr(1, 0, 32'h0);
        rc(1, 0, 32'hc0);
        for (int i = 3; i < 7; i++) begin
            wr(4, i, 32'h8000);
        end
        wr(4, 1, 32'h3);
        wr(4, 2, 32'h7);
        repeat (6) @(posedge clk);
        rc(4, 0, 32'h50);
        wr(4, 2, 32'h1);
        wr(4, 2, 32'h0);
        rc(4, 0, 32'hd0);
        // ****************************************
        // Manual reset keeps state, standby clears it
        // ****************************************
        mrst <= 1'b1;
        repeat (2) @(posedge clk);
        mrst <= 1'b0;
        rc(4, 0, 32'hd0);
        rc(0, 1, 32'h1000);
        stby <= 1'b1;
        repeat (2) @(posedge clk);
        stby <= 1'b0;
        rc(4, 0, 32'hc0);
        rc(0, 1, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(cs[k], 2, ctl[k]);
            rc(cs[k], 0, 32'hc0);
            wr(cs[k], 2, 32'h0);
            bus(1'b0, ad(cs[k], 1), 32'h0, rdata);
            check(32'(rdata[15]), 32'h0);
        end
        // Input capture on channel 3, flag A
        wr(3, 1, 32'h100);
        wr(3, 2, 32'h80);
        cap <= 20'h01000;
        repeat (4) @(posedge clk);
        cap <= 20'h0;
        repeat (4) @(posedge clk);
        rc(3, 3, 32'h100);
        rc(3, 0, 32'hc1);
        // Capture lands on the same edge as the clearing write
        cap <= 20'h01000;
        wr(3, 0, 32'h0);
        cap <= 20'h0;
        rc(3, 0, 32'hc1);
        final_report();
    end
endmodule : timer_channel_status_and_counter_tb
